// File: list_element_pkg.sv
// Contract
// - list elements are always 64 bits
// - bit 63 set gives element to device
// - opcode is bits 62 down to 56
// - opcode task groups decoded by range
// - control field is bits 55 to 48
// - low 48 bits carry opcode data
// - rx 0x12 loads checksum start addresses
// - rx 0x21 loads upper buffer address
// - rx 0x41 starts first-buffer dma write
// - rx 0x40 follow-up dma, skip one per packet
// - rx unsupported opcode stops and requests irq
// - zero ownership bit stops and requests irq
// - control bit 6 forces status burst
// - control bit 1 requests checksum; others ignored
// - tx fields little endian unless stated big
// - steer byte lanes, swap descriptor bytes
// - one transfer request per queue
// - tx unsupported opcode stops and requests irq
package list_element_pkg;
  localparam int ELEM_W = 64;
  localparam int OWN_BIT = 63;
  localparam int OPC_HI = 62;
  localparam int OPC_LO = 56;
  localparam int CTL_HI = 55;
  localparam int CTL_LO = 48;
  localparam int LEN_HI = 47;
  localparam int LEN_LO = 32;
  localparam int CTL_FORCE_STATUS = 6;
  localparam int CTL_CHECKSUM = 1;
  localparam logic [6:0] OPC_TCP_START = 7'h12;
  localparam logic [6:0] OPC_TCP_L = 7'h18;
  localparam logic [6:0] OPC_TCP_LW = 7'h19;
  localparam logic [6:0] OPC_TCP_LSW = 7'h1B;
  localparam logic [6:0] OPC_TCP_IS = 7'h16;
  localparam logic [6:0] OPC_TCP_LISW = 7'h1F;
  localparam logic [6:0] OPC_ADDR_HI = 7'h21;
  localparam logic [6:0] OPC_VLAN = 7'h22;
  localparam logic [6:0] OPC_ADDR_VLAN = 7'h23;
  localparam logic [6:0] OPC_LRGLEN = 7'h24;
  localparam logic [6:0] OPC_LRGLEN_VLAN = 7'h26;
  localparam logic [6:0] OPC_FOLLOW_BUF = 7'h40;
  localparam logic [6:0] OPC_FIRST_BUF = 7'h41;
  localparam logic [6:0] OPC_LARGE_SEND = 7'h43;
  localparam logic [2:0] GRP_TCP = 3'h1;
  localparam logic [2:0] GRP_REG = 3'h2;
  localparam logic [2:0] GRP_DMA = 3'h4;
  localparam logic [2:0] GRP_STATUS = 3'h6;
  localparam logic [2:0] GRP_SPECIAL = 3'h7;
  localparam logic [31:0] ADDR_HI_RESET = 32'h0000_0000;

  typedef enum logic [2:0] {
    GROUP_NONE = 3'h0,
    GROUP_TCP = 3'h1,
    GROUP_REG = 3'h2,
    GROUP_DMA = 3'h3,
    GROUP_STATUS = 3'h4,
    GROUP_SPECIAL = 3'h5
  } opc_group_t;

  typedef struct packed {
    logic own;
    logic [6:0] opcode;
    logic [7:0] control;
    logic [15:0] length;
    logic [31:0] addr_low;
  } list_elem_t;

  typedef struct packed {
    logic [7:0] control;
    logic [15:0] length;
    logic [63:0] addr;
    logic first;
    logic force_status_burst;
    logic checksum_calc_request;
  } dma_cmd_t;

  typedef struct packed {
    logic [15:0] start;
    logic [15:0] init_value;
    logic [15:0] write_pos;
    logic [7:0] lock_count;
  } tx_sum_t;
endpackage

// File: buffer_manager.sv
`timescale 1ns/1ps
module buffer_manager #(
  parameter int QUEUES = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // configuration: queue 0 is rx, 1 is tx
  input wire logic [QUEUES-1:0] queue_enable,
  input wire logic desc_byte_swap,
  // element fetch from host memory
  output logic [QUEUES-1:0] fetch_req,
  input wire logic [QUEUES-1:0] fetch_valid,
  input wire logic [63:0] fetch_data,
  input wire logic [2:0] fetch_byte_offset,
  // bus interface unit request side
  output logic [QUEUES-1:0] xfer_req,
  output logic [15:0] xfer_len,
  output logic [2:0] lane_select,
  output logic lane_reverse,
  input wire logic [QUEUES-1:0] xfer_done,
  input wire logic [15:0] fifo_space,
  // decoded results
  output list_element_pkg::dma_cmd_t rx_dma,
  output logic rx_dma_valid,
  output list_element_pkg::dma_cmd_t tx_dma,
  output logic tx_dma_valid,
  output logic [31:0] rx_checksum_start_load,
  output logic rx_checksum_start_strobe,
  output logic [31:0] upper_address_load,
  output logic [31:0] tx_upper_address,
  output logic [15:0] tx_vlan_tag,
  output logic [15:0] tx_segment_len,
  output list_element_pkg::tx_sum_t tx_sum,
  output list_element_pkg::opc_group_t last_group,
  // stop and interrupt
  output logic [QUEUES-1:0] halted,
  output logic irq_request,
  input wire logic [QUEUES-1:0] restart
);
  import list_element_pkg::*;

  // refused at elaboration: the sequencer hard-wires queue 0 as rx and 1 as tx
  if (QUEUES != 2) begin : g_bad_queues
    $error("buffer_manager serves exactly one rx and one tx queue");
  end

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_XFER = 4'b0100,
    ST_HALT = 4'b1000
  } q_state_t;

  q_state_t state [QUEUES];
  list_elem_t elem;
  logic [63:0] swapped;
  logic [7:0] ctl;
  logic [QUEUES-1:0] bad_opc;
  logic rx_skip_pending;
  logic [31:0] rx_upper;

  // descriptor words may arrive byte reversed
  always_comb begin
    swapped = fetch_data;
    if (desc_byte_swap) begin
      for (int i = 0; i < 8; i++) begin
        swapped[i*8 +: 8] = fetch_data[(7-i)*8 +: 8];
      end
    end
  end

  assign elem = list_elem_t'(swapped);
  assign ctl = elem.control;

  function automatic opc_group_t group_of(input logic [6:0] opc);
    case (opc[6:4])
      GRP_TCP: group_of = GROUP_TCP;
      GRP_REG: group_of = GROUP_REG;
      GRP_DMA: group_of = GROUP_DMA;
      GRP_STATUS: group_of = GROUP_STATUS;
      GRP_SPECIAL: group_of = GROUP_SPECIAL;
      default: group_of = GROUP_NONE;
    endcase
  endfunction

  always_comb begin
    bad_opc[0] = !(elem.opcode == OPC_TCP_START || elem.opcode == OPC_ADDR_HI ||
                   elem.opcode == OPC_FOLLOW_BUF || elem.opcode == OPC_FIRST_BUF);
    case (elem.opcode)
      OPC_TCP_START, OPC_TCP_IS, OPC_TCP_L, OPC_TCP_LW, OPC_TCP_LSW, OPC_TCP_LISW,
      OPC_ADDR_HI, OPC_VLAN, OPC_ADDR_VLAN, OPC_LRGLEN, OPC_LRGLEN_VLAN,
      OPC_FOLLOW_BUF, OPC_FIRST_BUF, OPC_LARGE_SEND: bad_opc[1] = 1'b0;
      default: bad_opc[1] = 1'b1;
    endcase
  end

  // per-queue sequencer; each queue owns one request line toward the bus unit
  for (genvar q = 0; q < QUEUES; q++) begin : g_q
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        state[q] <= ST_IDLE;
      end else begin
        case (state[q])
          ST_IDLE: if (queue_enable[q]) state[q] <= ST_FETCH;
          ST_FETCH: begin
            if (fetch_valid[q]) begin
              if (!elem.own || bad_opc[q]) begin
                state[q] <= ST_HALT;
              end else if (elem.opcode[6:4] == GRP_DMA[2:0] &&
                           !(q == 0 && rx_skip_pending && elem.opcode == OPC_FOLLOW_BUF)) begin
                state[q] <= ST_XFER;
              end
            end
          end
          ST_XFER: if (xfer_done[q]) state[q] <= ST_FETCH;
          ST_HALT: if (restart[q]) state[q] <= ST_IDLE;
          default: state[q] <= ST_IDLE;
        endcase
      end
    end

    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        fetch_req[q] <= 1'b0;
        xfer_req[q] <= 1'b0;
        halted[q] <= 1'b0;
      end else begin
        fetch_req[q] <= (state[q] == ST_FETCH) && !fetch_valid[q];
        xfer_req[q] <= (state[q] == ST_XFER) && !xfer_done[q];
        halted[q] <= (state[q] == ST_HALT);
      end
    end
  end

  // rx register loads and skip bookkeeping
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_upper <= ADDR_HI_RESET;
      upper_address_load <= ADDR_HI_RESET;
      rx_checksum_start_load <= 32'h0000_0000;
      rx_checksum_start_strobe <= 1'b0;
      rx_skip_pending <= 1'b1;
    end else begin
      rx_checksum_start_strobe <= 1'b0;
      if (state[0] == ST_FETCH && fetch_valid[0] && elem.own) begin
        if (elem.opcode == OPC_TCP_START) begin
          rx_checksum_start_load <= elem.addr_low;
          rx_checksum_start_strobe <= 1'b1;
        end
        if (elem.opcode == OPC_ADDR_HI) begin
          rx_upper <= elem.addr_low;
          upper_address_load <= elem.addr_low;
        end
        // first follow-up after a packet start is consumed without dma
        if (elem.opcode == OPC_FIRST_BUF) rx_skip_pending <= 1'b1;
        else if (elem.opcode == OPC_FOLLOW_BUF) rx_skip_pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_dma <= '0;
      rx_dma_valid <= 1'b0;
    end else begin
      rx_dma_valid <= 1'b0;
      if (state[0] == ST_FETCH && fetch_valid[0] && elem.own && elem.opcode[6:4] == GRP_DMA[2:0] &&
          !bad_opc[0] && !(rx_skip_pending && elem.opcode == OPC_FOLLOW_BUF)) begin
        rx_dma.control <= ctl;
        rx_dma.length <= elem.length;
        rx_dma.addr <= {rx_upper, elem.addr_low};
        rx_dma.first <= (elem.opcode == OPC_FIRST_BUF);
        rx_dma.force_status_burst <= ctl[CTL_FORCE_STATUS];
        rx_dma.checksum_calc_request <= ctl[CTL_CHECKSUM];
        rx_dma_valid <= 1'b1;
      end
    end
  end

  // tx loads; 16-bit fields named big endian are byte swapped here
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_upper_address <= ADDR_HI_RESET;
      tx_vlan_tag <= 16'h0000;
      tx_segment_len <= 16'h0000;
      tx_sum <= '0;
      tx_dma <= '0;
      tx_dma_valid <= 1'b0;
    end else begin
      tx_dma_valid <= 1'b0;
      if (state[1] == ST_FETCH && fetch_valid[1] && elem.own && !bad_opc[1]) begin
        if (elem.opcode == OPC_ADDR_HI || elem.opcode == OPC_ADDR_VLAN)
          tx_upper_address <= elem.addr_low;
        if (elem.opcode == OPC_VLAN || elem.opcode == OPC_ADDR_VLAN || elem.opcode == OPC_LRGLEN_VLAN)
          tx_vlan_tag <= {elem.length[7:0], elem.length[15:8]};
        if (elem.opcode == OPC_LRGLEN || elem.opcode == OPC_LRGLEN_VLAN)
          tx_segment_len <= elem.addr_low[15:0];
        if (elem.opcode[6:4] == GRP_TCP[2:0]) begin
          if (elem.opcode[3]) tx_sum.lock_count <= ctl;
          if (elem.opcode[2]) tx_sum.init_value <= {elem.length[7:0], elem.length[15:8]};
          if (elem.opcode[1]) tx_sum.start <= elem.addr_low[31:16];
          if (elem.opcode[0]) tx_sum.write_pos <= elem.addr_low[15:0];
        end
        if (elem.opcode[6:4] == GRP_DMA[2:0]) begin
          tx_dma.control <= ctl;
          tx_dma.length <= elem.length;
          tx_dma.addr <= {tx_upper_address, elem.addr_low};
          tx_dma.first <= (elem.opcode != OPC_FOLLOW_BUF);
          tx_dma.force_status_burst <= ctl[CTL_FORCE_STATUS];
          tx_dma.checksum_calc_request <= ctl[CTL_CHECKSUM];
          tx_dma_valid <= 1'b1;
        end
      end
    end
  end

  // lane steering, guaranteed length and interrupt request
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lane_select <= 3'h0;
      lane_reverse <= 1'b0;
      xfer_len <= 16'h0000;
      last_group <= GROUP_NONE;
      irq_request <= 1'b0;
    end else begin
      lane_select <= fetch_byte_offset;
      lane_reverse <= desc_byte_swap && (fetch_req != '0);
      if (rx_dma_valid) xfer_len <= (rx_dma.length < fifo_space) ? rx_dma.length : fifo_space;
      else if (tx_dma_valid) xfer_len <= (tx_dma.length < fifo_space) ? tx_dma.length : fifo_space;
      if (fetch_valid != '0) last_group <= group_of(elem.opcode);
      irq_request <= (state[0] == ST_HALT) || (state[1] == ST_HALT);
    end
  end

  AST_OWN_ZERO_HALTS: assert property (@(posedge core_clk) disable iff (!rst_n)
    state[0] == ST_FETCH && fetch_valid[0] && !elem.own |=> state[0] == ST_HALT ##1 irq_request)
    else $error("zero ownership did not halt rx");
  AST_RX_BAD_OPC: assert property (@(posedge core_clk) disable iff (!rst_n)
    state[0] == ST_FETCH && fetch_valid[0] && elem.own && bad_opc[0] |-> ##2 halted[0])
    else $error("rx unsupported opcode not halted");
  AST_TX_BAD_OPC: assert property (@(posedge core_clk) disable iff (!rst_n)
    state[1] == ST_FETCH && fetch_valid[1] && elem.own && bad_opc[1] |-> ##2 irq_request)
    else $error("tx unsupported opcode no irq");
  AST_CSUM_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
    state[0] == ST_FETCH && fetch_valid[0] && elem.own && elem.opcode == OPC_TCP_START
    |=> rx_checksum_start_strobe && rx_checksum_start_load == $past(elem.addr_low))
    else $error("checksum start not loaded");
  AST_ADDR_HI: assert property (@(posedge core_clk) disable iff (!rst_n)
    state[0] == ST_FETCH && fetch_valid[0] && elem.own && elem.opcode == OPC_ADDR_HI
    |=> upper_address_load == $past(elem.addr_low))
    else $error("upper address not loaded");
  AST_FIRST_DMA: assert property (@(posedge core_clk) disable iff (!rst_n)
    state[0] == ST_FETCH && fetch_valid[0] && elem.own && elem.opcode == OPC_FIRST_BUF
    |=> rx_dma_valid && rx_dma.first && rx_dma.length == $past(elem.length))
    else $error("first buffer dma missing");
  AST_SKIP: assert property (@(posedge core_clk) disable iff (!rst_n)
    state[0] == ST_FETCH && fetch_valid[0] && elem.own && elem.opcode == OPC_FOLLOW_BUF && rx_skip_pending
    |=> !rx_dma_valid)
    else $error("skipped buffer started dma");
  AST_CTL_BITS: assert property (@(posedge core_clk) disable iff (!rst_n)
    rx_dma_valid |-> rx_dma.force_status_burst == rx_dma.control[6] &&
    rx_dma.checksum_calc_request == rx_dma.control[1])
    else $error("control bits mis-decoded");
  AST_LEN_BOUND: assert property (@(posedge core_clk) disable iff (!rst_n)
    rx_dma_valid |=> xfer_len <= $past(fifo_space))
    else $error("guaranteed length exceeds fifo space");

  COV_RX_FIRST: cover property (@(posedge core_clk) rx_dma_valid && rx_dma.first);
  COV_RX_HALT: cover property (@(posedge core_clk) halted[0]);
  COV_TX_DMA: cover property (@(posedge core_clk) tx_dma_valid);
  COV_RESTART: cover property (@(posedge core_clk) halted[0] ##1 restart[0]);
endmodule

// File: host_list_model.sv
`timescale 1ns/1ps
module host_list_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // element fetch
  input wire logic [1:0] fetch_req,
  output logic [1:0] fetch_valid,
  output logic [63:0] fetch_data,
  // transfer completion
  input wire logic [1:0] xfer_req,
  output logic [1:0] xfer_done,
  input wire logic stall
);
  logic [63:0] list_q [2][$];
  int gap;
  int xfer_wait;
  function automatic int pending();
    return list_q[0].size() + list_q[1].size();
  endfunction
  // elements are queued whole, own bit included, never half written
  task automatic push(input int q, input logic [63:0] elem);
    list_q[q].push_back(elem);
  endtask
  initial begin
    fetch_valid = 2'b00;
    fetch_data = 64'hA5A5_5A5A_C3C3_3C3C;
    xfer_done = 2'b00;
    gap = 0;
    xfer_wait = 3;
  end
  // fetch_req lags the state by a cycle, so hold off after each hand-over
  always @(negedge core_clk) begin
    fetch_valid <= 2'b00;
    if (gap > 0)
      gap <= gap - 1;
    if (rst_n && !stall && gap == 0 && fetch_req[0] && list_q[0].size() > 0) begin
      fetch_data <= list_q[0].pop_front();
      fetch_valid <= 2'b01;
      gap <= 3;
    end else if (rst_n && !stall && gap == 0 && fetch_req[1] && list_q[1].size() > 0) begin
      fetch_data <= list_q[1].pop_front();
      fetch_valid <= 2'b10;
      gap <= 3;
    end else begin
      fetch_data <= ~fetch_data;
    end
  end
  always @(negedge core_clk) begin
    xfer_done <= 2'b00;
    if (xfer_req != 2'b00 && xfer_done == 2'b00 && !stall) begin
      if (xfer_wait == 0) begin
        xfer_done <= xfer_req[0] ? 2'b01 : 2'b10;
        xfer_wait <= 3;
      end else begin
        xfer_wait <= xfer_wait - 1;
      end
    end
  end
endmodule

// File: buffer_manager_tb.sv
`timescale 1ns/1ps
module buffer_manager_tb;
  import list_element_pkg::*;
  logic core_clk, rst_n, desc_byte_swap, rx_dma_valid, tx_dma_valid, sum_strobe, irq_request, lane_reverse;
  logic stall = 1'b0;
  logic len_due = 1'b0;
  logic [1:0] queue_enable, fetch_req, fetch_valid, xfer_req, xfer_done, halted, restart;
  logic [1:0] last_halted = 2'b00;
  logic [2:0] offset, lane_select;
  logic [15:0] xfer_len, fifo_space, vlan, seg_len;
  logic [31:0] seed, sum_load, upper_load, up, tx_upper;
  logic [31:0] noise = 32'h7ABC;
  logic [63:0] fetch_data, last_e;
  logic [6:0] bad [6] = '{OPC_FIRST_BUF, 7'h13, 7'h22, 7'h7F, 7'h30, 7'h50};
  dma_cmd_t rx_dma, tx_dma;
  tx_sum_t tx_sum;
  opc_group_t last_group;
  dma_cmd_t exp_dma[$];
  logic [31:0] exp_word[$];
  logic [15:0] exp_len[$];
  int errors, num_checks, cycles;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  buffer_manager u_buffer_manager (.core_clk(core_clk), .rst_n(rst_n), .queue_enable(queue_enable),
    .desc_byte_swap(desc_byte_swap), .fetch_req(fetch_req), .fetch_valid(fetch_valid),
    .fetch_data(fetch_data), .fetch_byte_offset(offset), .xfer_req(xfer_req), .xfer_len(xfer_len),
    .lane_select(lane_select), .lane_reverse(lane_reverse), .xfer_done(xfer_done), .fifo_space(fifo_space),
    .rx_dma(rx_dma), .rx_dma_valid(rx_dma_valid), .tx_dma(tx_dma), .tx_dma_valid(tx_dma_valid),
    .rx_checksum_start_load(sum_load), .rx_checksum_start_strobe(sum_strobe),
    .upper_address_load(upper_load), .tx_upper_address(tx_upper), .tx_vlan_tag(vlan), .tx_segment_len(seg_len),
    .tx_sum(tx_sum), .last_group(last_group), .halted(halted), .irq_request(irq_request), .restart(restart));
  host_list_model u_host_list_model (.core_clk(core_clk), .rst_n(rst_n), .fetch_req(fetch_req),
    .fetch_valid(fetch_valid), .fetch_data(fetch_data), .xfer_req(xfer_req), .xfer_done(xfer_done),
    .stall(stall));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(negedge core_clk) begin
    noise <= lfsr(noise);
    stall <= noise[0] & noise[3];
  end
  task automatic cmp_dma(input dma_cmd_t got, input dma_cmd_t exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t dma got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t word got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // res: 0 none, 1 first dma, 2 follow dma, 3 checksum load, above 8 halt word
  task automatic send(input int q, input logic own, input logic [6:0] opc, input logic [7:0] ctl,
                      input logic [31:0] upper, input int res);
    logic [63:0] e;
    logic [63:0] s;
    dma_cmd_t d;
    seed = lfsr(seed);
    e = {own, opc, ctl, seed[15:0], seed[7:0], seed[31:8]};
    // address-high loads must carry the upper word the later dma expects
    if (opc == OPC_ADDR_HI || opc == OPC_ADDR_VLAN)
      e[31:0] = upper;
    last_e = e;
    d = '{ctl, e[47:32], {upper, e[31:0]}, res == 1, ctl[6], ctl[1]};
    if (res == 1 || res == 2) begin
      exp_dma.push_back(d);
      exp_len.push_back(e[47:32] < fifo_space ? e[47:32] : fifo_space);
    end
    if (res == 3)
      exp_word.push_back(e[31:0]);
    if (res > 8)
      exp_word.push_back(res - 8);
    s = {<<8{e}};
    u_host_list_model.push(q, desc_byte_swap ? s : e);
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (u_host_list_model.pending() + exp_dma.size() + exp_word.size() + exp_len.size() != 0 && n < 800) begin
      @(negedge core_clk);
      n++;
    end
    repeat (4) @(negedge core_clk);
    if (n >= 800) begin
      errors++;
      $display("[ERR] %0t results missing", $time);
    end
  endtask
  always @(negedge core_clk) begin
    if (len_due)
      cmp_word({16'h0, xfer_len}, {16'h0, exp_len.pop_front()});
    len_due <= (rx_dma_valid === 1'b1) || (tx_dma_valid === 1'b1);
    if (rx_dma_valid === 1'b1)
      cmp_dma(rx_dma, exp_dma.pop_front());
    if (tx_dma_valid === 1'b1)
      cmp_dma(tx_dma, exp_dma.pop_front());
    if (sum_strobe === 1'b1)
      cmp_word(sum_load, exp_word.pop_front());
    if (halted !== last_halted && halted !== 2'b00)
      cmp_word({29'h0, halted, irq_request}, exp_word.pop_front());
    last_halted <= halted;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    rst_n = 1'b0;
    queue_enable = 2'b00;
    desc_byte_swap = 1'b0;
    restart = 2'b00;
    seed = 32'h7ABC;
    offset = 3'h5;
    fifo_space = 16'h0;
    up = 32'h0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    seed = lfsr(seed);
    fifo_space = {1'b0, seed[14:0]};
    offset = seed[18:16];
    queue_enable = 2'b11;
    up = lfsr(seed);
    send(0, 1'b1, OPC_FOLLOW_BUF, 8'h00, up, 0);
    send(0, 1'b1, OPC_ADDR_HI, 8'hFF, up, 0);
    send(0, 1'b1, OPC_TCP_START, 8'hFF, up, 3);
    for (int i = 0; i < 8; i++) begin
      drain();
      desc_byte_swap = i[2];
      seed = lfsr(seed);
      send(0, 1'b1, OPC_FIRST_BUF, {seed[7], i[0], seed[5:2], i[1], seed[0]}, up, 1);
      send(0, 1'b1, OPC_FOLLOW_BUF, seed[15:8], up, 0);
      send(0, 1'b1, OPC_FOLLOW_BUF, seed[23:16], up, 2);
    end
    drain();
    cmp_word(upper_load, up);
    cmp_word({31'h0, lane_reverse}, 32'h1);
    desc_byte_swap = 1'b0;
    for (int k = 0; k < 6; k++) begin
      send(k < 4 ? 0 : 1, k != 0, bad[k], 8'h00, up, k < 4 ? 11 : 13);
      drain();
      restart = k < 4 ? 2'b01 : 2'b10;
      @(negedge core_clk);
      restart = 2'b00;
      repeat (3) @(negedge core_clk);
      cmp_word({29'h0, halted, irq_request}, 32'h0);
    end
    up = lfsr(seed);
    send(1, 1'b1, OPC_TCP_LISW, 8'h5A, up, 0);
    drain();
    cmp_word({tx_sum.start, tx_sum.write_pos}, last_e[31:0]);
    cmp_word({tx_sum.init_value, 8'h00, tx_sum.lock_count}, {last_e[39:32], last_e[47:40], 16'h005A});
    cmp_word({29'h0, last_group}, {29'h0, GROUP_TCP});
    send(1, 1'b1, OPC_LRGLEN_VLAN, 8'h00, up, 0);
    drain();
    cmp_word({vlan, seg_len}, {last_e[39:32], last_e[47:40], last_e[15:0]});
    cmp_word({29'h0, last_group}, {29'h0, GROUP_REG});
    send(1, 1'b1, OPC_ADDR_VLAN, 8'h00, up, 0);
    drain();
    cmp_word(tx_upper, up);
    cmp_word({16'h0, vlan}, {16'h0, last_e[39:32], last_e[47:40]});
    send(1, 1'b1, OPC_ADDR_HI, 8'h00, up, 0);
    send(1, 1'b1, OPC_FIRST_BUF, 8'h42, up, 1);
    send(1, 1'b1, OPC_FOLLOW_BUF, 8'h80, up, 2);
    drain();
    cmp_word({29'h0, last_group}, {29'h0, GROUP_DMA});
    cmp_word({29'h0, lane_select}, {29'h0, offset});
    end_of_test();
  end
endmodule
